// ==== shared/pcts_pkg.sv ====
// constants for the pulse counter threshold and status registers
package pcts_pkg;
   // register addresses on the special function register bus
   localparam logic [7:0] PCTS_ADDR_STATUS = 8'hc1;
   localparam logic [7:0] PCTS_ADDR_THRESH = 8'he4;
   localparam logic [7:0] PCTS_RESET_STATUS = 8'h00;
   localparam logic [7:0] PCTS_RESET_THRESH = 8'h01;
   localparam logic [7:0] PCTS_READ_ZERO    = 8'h00;
   // threshold register fields
   localparam int PCTS_TH_HI_MSB  = 7;
   localparam int PCTS_TH_HI_LSB  = 6;
   localparam int PCTS_TH_LO_MSB  = 5;
   localparam int PCTS_TH_LO_LSB  = 4;
   localparam int PCTS_TH_FORCE_PULLDOWN   = 3;
   localparam int PCTS_TH_PUP     = 2;
   localparam int PCTS_TH_RSVD    = 1;
   localparam int PCTS_TH_LAST_READ_OK = 0;
   // status register fields
   localparam int PCTS_ST_FLUTTER = 7;
   localparam int PCTS_ST_DIR     = 6;
   localparam int PCTS_ST_STATE_MSB = 5;
   localparam int PCTS_ST_STATE_LSB = 4;
   localparam int PCTS_ST_PREV_B  = 3;
   localparam int PCTS_ST_PREV_A  = 2;
   localparam int PCTS_ST_CUR_B   = 1;
   localparam int PCTS_ST_CUR_A   = 0;
   // counter mode codes
   localparam logic [1:0] PCTS_MODE_OFF    = 2'b00;
   localparam logic [1:0] PCTS_MODE_SINGLE = 2'b01;
   localparam logic [1:0] PCTS_MODE_DUAL   = 2'b10;
   localparam logic [1:0] PCTS_MODE_QUAD   = 2'b11;
   // threshold percentages of the io supply, indexed by field code
   localparam logic [6:0] PCTS_HI_PCT_00 = 7'd59;
   localparam logic [6:0] PCTS_HI_PCT_01 = 7'd63;
   localparam logic [6:0] PCTS_HI_PCT_10 = 7'd50;
   localparam logic [6:0] PCTS_HI_PCT_11 = 7'd55;
   localparam logic [6:0] PCTS_LO_PCT_00 = 7'd42;
   localparam logic [6:0] PCTS_LO_PCT_01 = 7'd46;
   localparam logic [6:0] PCTS_LO_PCT_10 = 7'd34;
   localparam logic [6:0] PCTS_LO_PCT_11 = 7'd38;
   // edges of the other input that mark flutter on one edge type
   localparam logic [2:0] PCTS_FLUTTER_EDGES = 3'd4;
   // quadrature position, written as second input then first input
   typedef enum logic [1:0] {
      PCTS_POS_LL = 2'b00,
      PCTS_POS_LH = 2'b01,
      PCTS_POS_HH = 2'b11,
      PCTS_POS_HL = 2'b10
   } pcts_pos_e;
endpackage

// ==== verilog/pcts_state_tracker.sv ====
// quadrature position, direction, flutter and previous integrator outputs
`timescale 1ns/1ps
module pcts_state_tracker
   import pcts_pkg::*;
(
   input  wire logic       core_clk,  // system clock
   input  wire logic       rstn,      // async reset, active low
   input  wire logic       integA,    // first input integrator output
   input  wire logic       integB,    // second input integrator output
   input  wire logic       quadMode,  // counter mode is quadrature
   output logic            prevA,     // first input previous output
   output logic            prevB,     // second input previous output
   output pcts_pos_e       posState,  // current quadrature position
   output logic            direction, // 0 counter clockwise, 1 clockwise
   output logic            flutter    // flutter detected
);
   pcts_pos_e next_posState;
   logic [3:0] ownEdge;
   logic [3:0] otherEdge;
   logic [3:0] edgeHit;
   logic [2:0] edgeCnt [4];
   logic       curA;
   logic       curB;

   assign next_posState = pcts_pos_e'({integB, integA});
   assign curA = posState[0];
   assign curB = posState[1];

   // position register follows the integrator pair every cycle
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         posState <= PCTS_POS_LL;
      end else begin
         posState <= next_posState; // RULE10
      end
   end

   // previous outputs keep the value held before the last change
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         prevA <= 1'b0;
         prevB <= 1'b0;
      end else begin
         if (integA != curA) begin
            prevA <= curA; // RULE11
         end
         if (integB != curB) begin
            prevB <= curB; // RULE11
         end
      end
   end

   // direction from the step taken; a double step leaves it alone
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         direction <= 1'b0;
      end else if (quadMode && (^(next_posState ^ posState))) begin
         case (posState)
            PCTS_POS_LL: direction <= (next_posState == PCTS_POS_HL); // RULE9
            PCTS_POS_LH: direction <= (next_posState == PCTS_POS_LL); // RULE9
            PCTS_POS_HH: direction <= (next_posState == PCTS_POS_LH); // RULE9
            PCTS_POS_HL: direction <= (next_posState == PCTS_POS_HH); // RULE9
            default:     direction <= direction;
         endcase
      end
   end

   // edge types: 0 a rise, 1 a fall, 2 b rise, 3 b fall
   assign ownEdge[0] = integA & ~curA;
   assign ownEdge[1] = ~integA & curA;
   assign ownEdge[2] = integB & ~curB;
   assign ownEdge[3] = ~integB & curB;
   assign otherEdge[0] = integB ^ curB;
   assign otherEdge[1] = integB ^ curB;
   assign otherEdge[2] = integA ^ curA;
   assign otherEdge[3] = integA ^ curA;

   // one counter per edge type: reset by its own edge, bumped by the other input
   for (genvar e = 0; e < 4; e++) begin : g_edge
      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            edgeCnt[e] <= 3'd0;
         end else if (!quadMode || ownEdge[e]) begin
            edgeCnt[e] <= 3'd0;
         end else if (otherEdge[e] && edgeCnt[e] != PCTS_FLUTTER_EDGES) begin
            edgeCnt[e] <= edgeCnt[e] + 3'd1; // saturates so the flag holds
         end
      end
      assign edgeHit[e] = (edgeCnt[e] == PCTS_FLUTTER_EDGES);
   end

   // flag clears again once every edge type is back in step
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         flutter <= 1'b0;
      end else begin
         flutter <= quadMode & (|edgeHit); // RULE8
      end
   end
endmodule

// ==== verilog/pcts_regs.sv ====
// threshold control and status registers of the pulse counter
//
// Functional notes
// RULE1: high threshold field picks 50, 55, 59 or 63 percent of supply.
// RULE2: low threshold field picks 34, 38, 42 or 46 percent of supply.
// RULE3: force pulldown bit grounds both inputs; clear forces no pulldown.
// RULE4: force pullup holds pullup on; clear applies it only at duty cycle.
// RULE5: pulldown wins when both force bits are set.
// RULE6: read valid bit reports whether the last real-time read was good.
// RULE7: reading the threshold register returns read valid to one; resets one.
// RULE8: flutter flag sets in quadrature mode when edge counts fall out of step.
// RULE9: direction bit, quadrature only: 0 for LL-LH-HH-HL, 1 for LL-HL-HH-LH.
// RULE10: status shows the internal state machine state as two bits.
// RULE11: status shows previous integrator outputs, second input above first.
// RULE12: status shows current integrator outputs, first input in bit zero.
// RULE13: mode field: 00 off, 01 single, 10 dual, 11 quadrature.
// RULE14: integrators count up on high, down on low, switch after threshold plus one.
// RULE15: status writes do nothing; reserved threshold bit ignores writes, reads zero.
`timescale 1ns/1ps
module pcts_regs
   import pcts_pkg::*;
(
   input  wire logic       core_clk,           // system clock
   input  wire logic       rstn,               // async reset, active low
   input  wire logic [7:0] sfrAddr,            // register address
   input  wire logic [7:0] sfrWrData,          // write data
   input  wire logic       sfrWe,              // write strobe
   input  wire logic       sfrRe,              // read strobe
   output logic      [7:0] sfrRdData,          // read data, one cycle late
   input  wire logic       integA,             // first input integrator output
   input  wire logic       integB,             // second input integrator output
   input  wire logic [1:0] counterModeSelect,  // mode field from mode register
   input  wire logic       rtReadBad,          // other real-time read was invalid
   input  wire logic       dutyPullupPhase,    // duty cycle pullup window
   output logic      [1:0] highThresholdSelect,// high threshold code
   output logic      [1:0] lowThresholdSelect, // low threshold code
   output logic      [6:0] highThresholdPct,   // high threshold, percent
   output logic      [6:0] lowThresholdPct,    // low threshold, percent
   output logic            pulldownOn,         // ground both inputs
   output logic            pullupOn,           // apply pullup to both inputs
   output logic            quadMode            // quadrature counting active
);
   logic       forcePulldown;
   logic       forcePullup;
   logic       lastReadOk;
   logic [7:0] statusWord;
   logic [7:0] next_statusWord;
   logic [7:0] threshWord;
   logic       statusRead;
   logic       threshRead;
   logic       threshWrite;
   logic       statusStale;
   logic       prevA;
   logic       prevB;
   logic       direction;
   logic       flutter;
   pcts_pos_e  posState;

   ////////////////////////////////////////////////////////////////////////
   // address decode
   assign statusRead  = sfrRe && (sfrAddr == PCTS_ADDR_STATUS);
   assign threshRead  = sfrRe && (sfrAddr == PCTS_ADDR_THRESH);
   assign threshWrite = sfrWe && (sfrAddr == PCTS_ADDR_THRESH);

   // mode decode; only quadrature feeds this block's logic
   assign quadMode = (counterModeSelect == PCTS_MODE_QUAD); // RULE13

   ////////////////////////////////////////////////////////////////////////
   // position, direction and flutter tracking
   pcts_state_tracker u_tracker (
      .core_clk  (core_clk),
      .rstn      (rstn),
      .integA    (integA),
      .integB    (integB),
      .quadMode  (quadMode),
      .prevA     (prevA),
      .prevB     (prevB),
      .posState  (posState),
      .direction (direction),
      .flutter   (flutter)
   );

   // status word assembled from tracker state; the integrators sit outside
   always_comb begin
      statusWord = PCTS_RESET_STATUS;
      statusWord[PCTS_ST_FLUTTER] = flutter;                          // RULE8
      statusWord[PCTS_ST_DIR]     = direction;                        // RULE9
      statusWord[PCTS_ST_STATE_MSB:PCTS_ST_STATE_LSB] = posState;     // RULE10
      statusWord[PCTS_ST_PREV_B]  = prevB;                            // RULE11
      statusWord[PCTS_ST_PREV_A]  = prevA;                            // RULE11
      statusWord[PCTS_ST_CUR_B]   = posState[1];                      // RULE12
      statusWord[PCTS_ST_CUR_A]   = posState[0];                      // RULE12
   end

   // a read that meets a change of the integrator pair may be torn
   assign next_statusWord = {statusWord[7:2], integB, integA};
   assign statusStale = (next_statusWord[1:0] != statusWord[1:0]); // RULE14

   ////////////////////////////////////////////////////////////////////////
   // threshold and pull control fields; status has no write path at all
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         highThresholdSelect <= PCTS_RESET_THRESH[PCTS_TH_HI_MSB:PCTS_TH_HI_LSB];
         lowThresholdSelect  <= PCTS_RESET_THRESH[PCTS_TH_LO_MSB:PCTS_TH_LO_LSB];
         forcePulldown       <= PCTS_RESET_THRESH[PCTS_TH_FORCE_PULLDOWN];
         forcePullup         <= PCTS_RESET_THRESH[PCTS_TH_PUP];
      end else if (threshWrite) begin
         highThresholdSelect <= sfrWrData[PCTS_TH_HI_MSB:PCTS_TH_HI_LSB]; // RULE1
         lowThresholdSelect  <= sfrWrData[PCTS_TH_LO_MSB:PCTS_TH_LO_LSB]; // RULE2
         forcePulldown       <= sfrWrData[PCTS_TH_FORCE_PULLDOWN];
         forcePullup         <= sfrWrData[PCTS_TH_PUP];
      end
   end

   // read valid: a bad read clears it, a threshold read sets it again;
   // the bad-read event wins so a failure is never hidden by the read
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         lastReadOk <= PCTS_RESET_THRESH[PCTS_TH_LAST_READ_OK]; // RULE7
      end else if (rtReadBad || (statusRead && statusStale)) begin
         lastReadOk <= 1'b0; // RULE6
      end else if (statusRead) begin
         lastReadOk <= 1'b1; // RULE6
      end else if (threshRead) begin
         lastReadOk <= 1'b1; // RULE7
      end else if (threshWrite) begin
         lastReadOk <= sfrWrData[PCTS_TH_LAST_READ_OK];
      end
   end

   // threshold register image; reserved bit is tied low
   always_comb begin
      threshWord = PCTS_READ_ZERO;
      threshWord[PCTS_TH_HI_MSB:PCTS_TH_HI_LSB] = highThresholdSelect;
      threshWord[PCTS_TH_LO_MSB:PCTS_TH_LO_LSB] = lowThresholdSelect;
      threshWord[PCTS_TH_FORCE_PULLDOWN]   = forcePulldown;
      threshWord[PCTS_TH_PUP]     = forcePullup;
      threshWord[PCTS_TH_RSVD]    = 1'b0; // RULE15
      threshWord[PCTS_TH_LAST_READ_OK] = lastReadOk;
   end

   // registered read data; unmapped addresses read zero
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sfrRdData <= PCTS_READ_ZERO;
      end else if (statusRead) begin
         sfrRdData <= statusWord;
      end else if (threshRead) begin
         sfrRdData <= threshWord;
      end else if (sfrRe) begin
         sfrRdData <= PCTS_READ_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // threshold codes to percentages, for the comparator trim
   always_comb begin
      case (highThresholdSelect)
         2'b00:   highThresholdPct = PCTS_HI_PCT_00; // RULE1
         2'b01:   highThresholdPct = PCTS_HI_PCT_01; // RULE1
         2'b10:   highThresholdPct = PCTS_HI_PCT_10; // RULE1
         default: highThresholdPct = PCTS_HI_PCT_11; // RULE1
      endcase
   end

   always_comb begin
      case (lowThresholdSelect)
         2'b00:   lowThresholdPct = PCTS_LO_PCT_00; // RULE2
         2'b01:   lowThresholdPct = PCTS_LO_PCT_01; // RULE2
         2'b10:   lowThresholdPct = PCTS_LO_PCT_10; // RULE2
         default: lowThresholdPct = PCTS_LO_PCT_11; // RULE2
      endcase
   end

   // pull drive; pulldown overrides so the pads never fight
   assign pulldownOn = forcePulldown; // RULE3
   assign pullupOn   = ~forcePulldown & (forcePullup | dutyPullupPhase); // RULE4 RULE5

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_hi_pct; // RULE1
      @(posedge core_clk) disable iff (!rstn)
      threshWrite && sfrWrData[7:6] == 2'b10 |=> highThresholdPct == 7'd50;
   endproperty
   a_hi_pct: assert property (p_hi_pct) else $error("high threshold percent wrong"); // RULE1

   property p_lo_pct; // RULE2
      @(posedge core_clk) disable iff (!rstn)
      threshWrite && sfrWrData[5:4] == 2'b01 |=> lowThresholdPct == 7'd46;
   endproperty
   a_lo_pct: assert property (p_lo_pct) else $error("low threshold percent wrong"); // RULE2

   property p_pulldown; // RULE3
      @(posedge core_clk) disable iff (!rstn)
      threshWrite |=> pulldownOn == $past(sfrWrData[3]);
   endproperty
   a_pulldown: assert property (p_pulldown) else $error("pulldown does not follow write"); // RULE3

   property p_pullup_forced; // RULE4
      @(posedge core_clk) disable iff (!rstn)
      forcePullup && !forcePulldown |-> pullupOn;
   endproperty
   a_pullup_forced: assert property (p_pullup_forced) else $error("forced pullup not applied"); // RULE4

   property p_pd_priority; // RULE5
      @(posedge core_clk) disable iff (!rstn)
      pulldownOn |-> !pullupOn;
   endproperty
   a_pd_priority: assert property (p_pd_priority) else $error("pullup on during pulldown"); // RULE5

   property p_bad_read; // RULE6
      @(posedge core_clk) disable iff (!rstn)
      rtReadBad |=> !threshWord[0] ##1 (threshWord[0] || !$past(threshRead) || $past(rtReadBad));
   endproperty
   a_bad_read: assert property (p_bad_read) else $error("bad read not recorded"); // RULE6

   property p_read_restores; // RULE7
      @(posedge core_clk) disable iff (!rstn)
      threshRead && !rtReadBad |=> lastReadOk && sfrRdData[0] == $past(lastReadOk);
   endproperty
   a_read_restores: assert property (p_read_restores) else $error("read valid not restored"); // RULE7

   property p_flutter_mode; // RULE8
      @(posedge core_clk) disable iff (!rstn)
      !quadMode [*2] |-> !flutter;
   endproperty
   a_flutter_mode: assert property (p_flutter_mode) else $error("flutter outside quadrature"); // RULE8

   property p_dir_ccw; // RULE9
      @(posedge core_clk) disable iff (!rstn)
      quadMode && posState == PCTS_POS_LL && {integB, integA} == 2'b01 |=> !direction;
   endproperty
   a_dir_ccw: assert property (p_dir_ccw) else $error("direction wrong on ccw step"); // RULE9

   property p_current; // RULE12
      @(posedge core_clk) disable iff (!rstn)
      1'b1 |=> statusWord[1:0] == $past({integB, integA});
   endproperty
   a_current: assert property (p_current) else $error("current integrator bits wrong"); // RULE12

   property p_status_ro; // RULE15
      @(posedge core_clk) disable iff (!rstn)
      sfrWe && sfrAddr == PCTS_ADDR_STATUS |=> $stable(threshWord[7:2]);
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("status write changed state"); // RULE15
endmodule

// ==== testbench/pcts_reed_sensor.sv ====
// reed switch sensor model driving the two debounced input levels
`timescale 1ns/1ps
module pcts_reed_sensor (
   input  wire logic core_clk, // system clock
   output logic      integA,   // first input level
   output logic      integB    // second input level
);
   ////////////////////////////////////////////////////////////////////////////
   // both switches open at power up, so both levels start low
   initial begin
      integA = 1'b0;
      integB = 1'b0;
   end
   // move to a new pair just after a falling edge, then dwell
   // a long dwell keeps the pair still so status reads stay valid
   task automatic move(input logic b, input logic a, input int dwell);
      @(negedge core_clk);
      integB = b;
      integA = a;
      repeat (dwell) @(negedge core_clk);
   endtask
endmodule

// ==== testbench/pulse_counter_threshold_status_regs_tb.sv ====
// self-checking bench for the threshold and status registers
`timescale 1ns/1ps
module pulse_counter_threshold_status_regs_tb;
   import pcts_pkg::*;
   logic       core_clk, rstn, sfrWe, sfrRe, integA, integB, rtReadBad, dutyPullupPhase;
   logic [7:0] sfrAddr, sfrWrData, sfrRdData, d;
   logic [1:0] counterModeSelect, highThresholdSelect, lowThresholdSelect;
   logic [6:0] highThresholdPct, lowThresholdPct;
   logic       pulldownOn, pullupOn, quadMode;
   logic [6:0] hiPct [4] = '{7'd59, 7'd63, 7'd50, 7'd55};
   logic [6:0] loPct [4] = '{7'd42, 7'd46, 7'd34, 7'd38};
   int         fails, checkCount;
   ////////////////////////////////////////////////////////////////////////////
   // clock at 100 MHz
   always #5 core_clk = ~core_clk;
   pcts_regs dut (.core_clk(core_clk), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
      .sfrWe(sfrWe), .sfrRe(sfrRe), .sfrRdData(sfrRdData), .integA(integA), .integB(integB),
      .counterModeSelect(counterModeSelect), .rtReadBad(rtReadBad), .dutyPullupPhase(dutyPullupPhase),
      .highThresholdSelect(highThresholdSelect), .lowThresholdSelect(lowThresholdSelect),
      .highThresholdPct(highThresholdPct), .lowThresholdPct(lowThresholdPct),
      .pulldownOn(pulldownOn), .pullupOn(pullupOn), .quadMode(quadMode));
   pcts_reed_sensor sensor (.core_clk(core_clk), .integA(integA), .integB(integB));
   ////////////////////////////////////////////////////////////////////////////
   // shared compare, bus cycles and closing
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checkCount++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge core_clk);
      sfrAddr = a;
      sfrWrData = v;
      sfrWe = 1'b1;
      @(negedge core_clk);
      sfrWe = 1'b0;
   endtask
   // read data stands until the next read, so sample a full cycle late
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge core_clk);
      sfrAddr = a;
      sfrRe = 1'b1;
      @(negedge core_clk);
      sfrRe = 1'b0;
      @(negedge core_clk);
      v = sfrRdData;
   endtask
   task automatic bad_pulse();
      @(negedge core_clk);
      rtReadBad = 1'b1;
      @(negedge core_clk);
      rtReadBad = 1'b0;
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checkCount, fails);
      if (fails == 0 && checkCount > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      rd(PCTS_ADDR_THRESH, d);
      chk(d, 8'h01, "threshold reset");
      rd(PCTS_ADDR_STATUS, d);
      chk(d, 8'h00, "status reset");
      chk({pulldownOn, pullupOn}, 8'h00, "pulls after reset");
   endtask
   // every code of both fields; reserved bit written one must read zero
   task automatic t_thresholds();
      for (int c = 0; c < 4; c++) begin
         wr(PCTS_ADDR_THRESH, {c[1:0], c[1:0], 4'b0011});
         chk({1'b0, highThresholdPct}, {1'b0, hiPct[c]}, "high percent");
         chk({1'b0, lowThresholdPct}, {1'b0, loPct[c]}, "low percent");
         chk({highThresholdSelect, lowThresholdSelect}, {4'h0, c[1:0], c[1:0]}, "codes");
         rd(PCTS_ADDR_THRESH, d);
         chk(d, {c[1:0], c[1:0], 4'b0001}, "threshold readback");
      end
   endtask
   // all eight combinations of pulldown, pullup and duty window
   task automatic t_pulls();
      for (int i = 0; i < 8; i++) begin
         dutyPullupPhase = i[0];
         wr(PCTS_ADDR_THRESH, {4'h0, i[2], i[1], 2'b01});
         chk({7'h0, pulldownOn}, {7'h0, i[2]}, "pulldown");
         chk({7'h0, pullupOn}, {7'h0, !i[2] && (i[1] || i[0])}, "pullup");
      end
   endtask
   task automatic t_read_valid();
      bad_pulse();
      rd(PCTS_ADDR_THRESH, d);
      chk(d, 8'h0c, "invalid shown");
      rd(PCTS_ADDR_THRESH, d);
      chk(d, 8'h0d, "set back by read");
      wr(PCTS_ADDR_THRESH, 8'h0c);
      rd(PCTS_ADDR_THRESH, d);
      chk(d, 8'h0c, "written zero");
      rd(PCTS_ADDR_THRESH, d);
      chk(d, 8'h0d, "set back again");
      bad_pulse();
      rd(PCTS_ADDR_STATUS, d);
      rd(PCTS_ADDR_THRESH, d);
      chk(d, 8'h0d, "status read valid");
   endtask
   task automatic t_modes();
      for (int m = 0; m < 4; m++) begin
         @(negedge core_clk);
         counterModeSelect = m[1:0];
         @(negedge core_clk);
         chk({7'h0, quadMode}, {7'h0, m == 3}, "mode decode");
      end
   endtask
   // one turn each way, then a step outside quadrature
   task automatic t_rotation();
      sensor.move(1'b0, 1'b1, 3);
      rd(PCTS_ADDR_STATUS, d);
      chk(d, 8'h11, "first step");
      sensor.move(1'b1, 1'b1, 3);
      sensor.move(1'b1, 1'b0, 3);
      sensor.move(1'b0, 1'b0, 3);
      rd(PCTS_ADDR_STATUS, d);
      chk(d, 8'h0c, "counter clockwise turn");
      sensor.move(1'b1, 1'b0, 3);
      rd(PCTS_ADDR_STATUS, d);
      chk(d, 8'h66, "clockwise step");
      sensor.move(1'b1, 1'b1, 3);
      sensor.move(1'b0, 1'b1, 3);
      sensor.move(1'b0, 1'b0, 3);
      rd(PCTS_ADDR_STATUS, d);
      chk(d, 8'h4c, "clockwise turn");
      // both inputs move at once: the step is ambiguous, direction must hold
      sensor.move(1'b1, 1'b1, 3);
      rd(PCTS_ADDR_STATUS, d);
      chk(d & 8'h40, 8'h40, "double step holds direction");
      counterModeSelect = PCTS_MODE_SINGLE;
      sensor.move(1'b0, 1'b1, 3);
      rd(PCTS_ADDR_STATUS, d);
      chk(d & 8'h40, 8'h40, "direction held");
   endtask
   // first input chatters four times while the second stands still
   task automatic t_flutter();
      logic [7:0] snap;
      counterModeSelect = PCTS_MODE_QUAD;
      sensor.move(1'b1, 1'b1, 3);
      sensor.move(1'b0, 1'b1, 3);
      sensor.move(1'b0, 1'b0, 1);
      sensor.move(1'b0, 1'b1, 1);
      sensor.move(1'b0, 1'b0, 1);
      sensor.move(1'b0, 1'b1, 4);
      rd(PCTS_ADDR_STATUS, snap);
      chk(snap & 8'h80, 8'h80, "flutter flag");
      wr(PCTS_ADDR_STATUS, 8'h00);
      rd(PCTS_ADDR_STATUS, d);
      chk(d, snap, "status write ignored");
      rd(8'h00, d);
      chk(d, 8'h00, "unmapped read");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // main sequence, reset held for four cycles
   initial begin
      core_clk = 1'b0;
      rstn = 1'b0;
      sfrWe = 1'b0;
      sfrRe = 1'b0;
      sfrAddr = 8'h00;
      sfrWrData = 8'h00;
      rtReadBad = 1'b0;
      dutyPullupPhase = 1'b0;
      counterModeSelect = PCTS_MODE_QUAD;
      repeat (4) @(negedge core_clk);
      rstn = 1'b1;
      t_reset();
      t_thresholds();
      t_pulls();
      t_read_valid();
      t_modes();
      t_rotation();
      t_flutter();
      report_and_stop();
   end
   // watchdog, ample over the fewer than two hundred cycles the run needs
   initial begin
      #50000;
      fails++;
      report_and_stop();
   end
endmodule
